// File: sacc_conv_ctrl.v
// Summary of operation
// R01 - Five-bit channel code picks port pin, temp sensor, regulator, supply, ground or none.
// R02 - Conversion clock divides system clock, or the fast oscillator in burst.
// R03 - Divide ratio comes from the clock divide field of the config register.
// R04 - In software mode, writing one to the busy bit starts a conversion.
// R05 - In timer mode, the chosen timer overflow starts a conversion.
// R06 - In external mode, a rising edge on the start pin starts a conversion.
// R07 - Each finished set writes the result register and sets the done flag.
// R08 - Done flag raises the interrupt when enabled, else stays readable for polling.
// R09 - Busy bit reads one throughout conversion and clears itself on completion.
// R10 - Software polls the done flag, not the busy bit, to await completion.
// R11 - Completed result is readable as a high byte and low byte pair.
// R12 - Track mode clear, no burst: track except while converting; convert immediately.
// R13 - Track mode set, internal trigger: four conversion clocks of tracking first.
// R14 - Track mode set, external trigger: track while pin low, convert on rise.
// R15 - Burst powers up, converts and accumulates, then shuts down unaided.
// R16 - Sixteen-bit accumulator sums successive results.
// R17 - Software sets pins used as inputs to analog mode and crossbar skip.
// R18 - In burst one trigger launches repeat-count conversions: 1,4,8,16,32,64.
// R19 - Done flag sets only after repeat-count conversions are accumulated.
// R20 - In burst, triggers arriving before the burst ends are ignored.
// R21 - Start mode codes: 0 software, 1-3 timers 0-2, 4 external pin.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_map.vh"

module sacc_conv_ctrl (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  // Trigger and clock sources
  input wire extStartPin,
  input wire [2:0] timerOvf,
  input wire hfOsc,
  // Analog side
  input wire cmpIn,
  output wire [9:0] dacCode,
  output reg [15:0] pinSel,
  output reg tempSel,
  output reg ldoSel,
  output reg vddSel,
  output reg gndSel,
  output reg trackEn,
  output reg convPowerOn,
  // Interrupt request
  output reg convDoneIrq
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PWRUP = 4'b0010;
  localparam [3:0] ST_TRACK = 4'b0100;
  localparam [3:0] ST_CONV = 4'b1000;

  // Repeat code to conversion count
  function [6:0] repTarget;
    input [2:0] code;
    begin
      case (code)
        3'h1: repTarget = 7'h04;
        3'h2: repTarget = 7'h08;
        3'h3: repTarget = 7'h10;
        3'h4: repTarget = 7'h20;
        3'h5: repTarget = 7'h40;
        default: repTarget = 7'h01;
      endcase
    end
  endfunction

  reg [2:0] mode_q;
  reg tm_q;
  reg burst_q;
  reg done_q;
  reg ien_q;
  reg [4:0] div_q;
  reg [4:0] chan_q;
  reg [2:0] rep_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] tickCnt_q;
  reg [2:0] tickCnt_d;
  reg [6:0] convCnt_q;
  reg [15:0] acc_q;
  reg [15:0] result_q;
  reg extSync0_q;
  reg extSync1_q;
  reg extPrev_q;
  reg hwStart;
  reg sarStart;
  reg trackEn_d;

  wire convTick;
  wire sarDone;
  wire [9:0] sarResult;
  wire wrCtrl;
  wire swStart;
  wire startReq;
  wire extRise;
  wire busy;
  wire lastConv;
  wire [2:0] trackLen;
  wire [15:0] newAcc;

  assign wrCtrl = regWr && (regAddr == `SACC_OFS_CTRL);
  assign swStart = wrCtrl && regWdata[`SACC_CTRL_BUSY] &&
    (regWdata[`SACC_CTRL_MODE_HI:`SACC_CTRL_MODE_LO] == `SACC_MODE_SW); // [R04]
  assign extRise = extSync1_q & ~extPrev_q; // [R06]
  assign startReq = swStart | hwStart;
  assign busy = (state_q != ST_IDLE); // [R09]
  assign lastConv = ((convCnt_q + 7'h01) >= repTarget(rep_q)); // [R18] [R19]
  assign trackLen = tm_q ? `SACC_TRACK_CLKS : `SACC_BURST_TRACK_CLKS;
  assign newAcc = (convCnt_q == 7'h00) ? {6'h00, sarResult} :
    acc_q + {6'h00, sarResult}; // [R16]

  // Conversion clock: system clock or fast oscillator, divided by div_q + 1
  sacc_clk_div uClkDiv (
    .clk(clk),
    .nrst(nrst),
    .burstSel(burst_q), // [R02]
    .hfOsc(hfOsc),
    .divVal(div_q), // [R03]
    .tick(convTick)
  );

  sacc_sar_core uSar (
    .clk(clk),
    .nrst(nrst),
    .tick(convTick),
    .start(sarStart),
    .cmpIn(cmpIn),
    .dacCode(dacCode),
    .result(sarResult),
    .done(sarDone)
  );

  always @* begin
    case (mode_q)
      `SACC_MODE_TMR0: hwStart = timerOvf[0]; // [R05]
      `SACC_MODE_TMR1: hwStart = timerOvf[1]; // [R05]
      `SACC_MODE_TMR2: hwStart = timerOvf[2]; // [R05]
      `SACC_MODE_EXT: hwStart = extRise; // [R06] [R21]
      default: hwStart = 1'b0;
    endcase
  end

  // Sequencer; triggers are taken only in idle, so a running burst ignores them
  always @* begin
    state_d = state_q;
    tickCnt_d = tickCnt_q;
    sarStart = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (startReq) begin // [R20]
          tickCnt_d = 3'h0;
          if (burst_q) begin
            state_d = ST_PWRUP; // [R15]
          end else if (tm_q && (mode_q != `SACC_MODE_EXT)) begin
            state_d = ST_TRACK; // [R13]
          end else begin
            state_d = ST_CONV; // [R12] [R14]
            sarStart = 1'b1;
          end
        end
      end
      ST_PWRUP: begin
        if (convTick) begin
          if (tickCnt_q == `SACC_PWRUP_CLKS - 3'h1) begin
            state_d = ST_TRACK;
            tickCnt_d = 3'h0;
          end else begin
            tickCnt_d = tickCnt_q + 3'h1;
          end
        end
      end
      ST_TRACK: begin
        if (convTick) begin
          if (tickCnt_q == trackLen - 3'h1) begin // [R13]
            state_d = ST_CONV;
            sarStart = 1'b1;
          end else begin
            tickCnt_d = tickCnt_q + 3'h1;
          end
        end
      end
      ST_CONV: begin
        if (sarDone) begin
          tickCnt_d = 3'h0;
          if (burst_q && !lastConv) begin
            state_d = ST_TRACK; // [R18]
          end else begin
            state_d = ST_IDLE; // [R15]
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Track switch of the analog front end
  always @* begin
    case (state_q)
      ST_IDLE: begin
        if (burst_q) begin
          trackEn_d = 1'b0;
        end else if (tm_q && (mode_q == `SACC_MODE_EXT)) begin
          trackEn_d = ~extSync1_q; // [R14]
        end else begin
          trackEn_d = ~tm_q; // [R12]
        end
      end
      ST_TRACK: trackEn_d = 1'b1; // [R13]
      default: trackEn_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      tickCnt_q <= 3'h0;
      convCnt_q <= 7'h00;
      acc_q <= 16'h0000;
      result_q <= 16'h0000;
      extSync0_q <= 1'b0;
      extSync1_q <= 1'b0;
      extPrev_q <= 1'b0;
      trackEn <= 1'b0;
      convPowerOn <= 1'b0;
    end else begin
      state_q <= state_d;
      tickCnt_q <= tickCnt_d;
      extSync0_q <= extStartPin;
      extSync1_q <= extSync0_q;
      extPrev_q <= extSync1_q;
      trackEn <= trackEn_d;
      convPowerOn <= burst_q ? (state_d != ST_IDLE) : 1'b1; // [R15]
      if (sarDone) begin
        acc_q <= newAcc; // [R16]
        if (lastConv) begin
          result_q <= newAcc; // [R07] [R19]
          convCnt_q <= 7'h00;
        end else begin
          convCnt_q <= convCnt_q + 7'h01;
        end
      end
    end
  end

  // Software registers and done flag; a hardware set wins over a clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= `SACC_MODE_RST;
      tm_q <= 1'b0;
      burst_q <= 1'b0;
      done_q <= 1'b0;
      ien_q <= 1'b0;
      div_q <= `SACC_DIV_RST;
      chan_q <= `SACC_CHAN_RST;
      rep_q <= `SACC_REP_RST;
      convDoneIrq <= 1'b0;
    end else begin
      if (wrCtrl) begin
        mode_q <= regWdata[`SACC_CTRL_MODE_HI:`SACC_CTRL_MODE_LO];
        tm_q <= regWdata[`SACC_CTRL_TM];
        burst_q <= regWdata[`SACC_CTRL_BURST];
      end
      if (regWr && (regAddr == `SACC_OFS_CFG)) begin
        div_q <= regWdata[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO]; // [R03]
      end
      if (regWr && (regAddr == `SACC_OFS_MUX)) begin
        chan_q <= regWdata[4:0];
      end
      if (regWr && (regAddr == `SACC_OFS_REP)) begin
        rep_q <= regWdata[2:0];
      end
      if (regWr && (regAddr == `SACC_OFS_IEN)) begin
        ien_q <= regWdata[0];
      end
      if (sarDone && lastConv) begin
        done_q <= 1'b1; // [R07] [R19]
      end else if (wrCtrl && !regWdata[`SACC_CTRL_DONE]) begin
        done_q <= 1'b0;
      end
      convDoneIrq <= ien_q & done_q; // [R08]
    end
  end

  // Channel decode to analog switches
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinSel <= 16'h0000;
      tempSel <= 1'b0;
      ldoSel <= 1'b0;
      vddSel <= 1'b0;
      gndSel <= 1'b0;
    end else begin
      pinSel <= chan_q[4] ? 16'h0000 : (16'h0001 << chan_q[3:0]); // [R01]
      tempSel <= (chan_q == `SACC_CH_TEMP); // [R01]
      ldoSel <= (chan_q == `SACC_CH_LDO);
      vddSel <= (chan_q == `SACC_CH_VDD);
      gndSel <= (chan_q == `SACC_CH_GND);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `SACC_OFS_CTRL: regRdata <= {done_q, busy, tm_q, burst_q, 1'b0, mode_q}; // [R08] [R09]
        `SACC_OFS_CFG: regRdata <= {div_q, 3'h0};
        `SACC_OFS_MUX: regRdata <= {3'h0, chan_q};
        `SACC_OFS_RESH: regRdata <= result_q[15:8]; // [R11]
        `SACC_OFS_RESL: regRdata <= result_q[7:0]; // [R11]
        `SACC_OFS_REP: regRdata <= {5'h00, rep_q};
        `SACC_OFS_IEN: regRdata <= {7'h00, ien_q};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule // sacc_conv_ctrl
`default_nettype wire

// File: sacc_map.vh
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// Register offsets on the 3-bit register address
`define SACC_OFS_CTRL 3'h0
`define SACC_OFS_CFG 3'h1
`define SACC_OFS_MUX 3'h2
`define SACC_OFS_RESH 3'h3
`define SACC_OFS_RESL 3'h4
`define SACC_OFS_REP 3'h5
`define SACC_OFS_IEN 3'h6

// Control register fields
`define SACC_CTRL_DONE 7
`define SACC_CTRL_BUSY 6
`define SACC_CTRL_TM 5
`define SACC_CTRL_BURST 4
`define SACC_CTRL_MODE_HI 2
`define SACC_CTRL_MODE_LO 0

// Config register clock divide field
`define SACC_CFG_DIV_HI 7
`define SACC_CFG_DIV_LO 3

// Reset values
`define SACC_MODE_RST 3'h0
`define SACC_DIV_RST 5'h1F
`define SACC_CHAN_RST 5'h1F
`define SACC_REP_RST 3'h0

// Start mode codes
`define SACC_MODE_SW 3'h0
`define SACC_MODE_TMR0 3'h1
`define SACC_MODE_TMR1 3'h2
`define SACC_MODE_TMR2 3'h3
`define SACC_MODE_EXT 3'h4

// Internal channel codes; codes above GND select nothing
`define SACC_CH_TEMP 5'h10
`define SACC_CH_LDO 5'h11
`define SACC_CH_VDD 5'h12
`define SACC_CH_GND 5'h13

// Timing in conversion clock periods
`define SACC_TRACK_CLKS 3'h4
`define SACC_BURST_TRACK_CLKS 3'h1
`define SACC_PWRUP_CLKS 3'h2

`endif

// File: sacc_clk_div.v
`timescale 1ns/1ps
`default_nettype none
`include "sacc_map.vh"

module sacc_clk_div (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Source and ratio
  input wire burstSel,
  input wire hfOsc,
  input wire [4:0] divVal,
  // Conversion clock tick
  output reg tick
);

  reg hfSync0_q;
  reg hfSync1_q;
  reg hfPrev_q;
  reg [4:0] cnt_q;
  wire srcPulse;

  // Burst counts oscillator edges, otherwise every system clock
  assign srcPulse = burstSel ? (hfSync1_q & ~hfPrev_q) : 1'b1;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hfSync0_q <= 1'b0;
      hfSync1_q <= 1'b0;
      hfPrev_q <= 1'b0;
      cnt_q <= 5'h00;
      tick <= 1'b0;
    end else begin
      hfSync0_q <= hfOsc;
      hfSync1_q <= hfSync0_q;
      hfPrev_q <= hfSync1_q;
      tick <= 1'b0;
      if (srcPulse) begin
        if (cnt_q >= divVal) begin
          cnt_q <= 5'h00;
          tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

endmodule // sacc_clk_div
`default_nettype wire

// File: sacc_sar_core.v
`timescale 1ns/1ps
`default_nettype none

module sacc_sar_core (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire tick,
  input wire start,
  // Analog comparator, high when input is at or above the trial code
  input wire cmpIn,
  // Results
  output reg [9:0] dacCode,
  output reg [9:0] result,
  output reg done
);

  reg cmpSync0_q;
  reg cmpSync1_q;
  reg busy_q;
  reg [3:0] bit_q;
  reg [1:0] settle_q;
  reg [9:0] trial;

  always @* begin
    trial = dacCode;
    if (!cmpSync1_q) begin
      trial[bit_q] = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmpSync0_q <= 1'b0;
      cmpSync1_q <= 1'b0;
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      settle_q <= 2'h0;
      dacCode <= 10'h000;
      result <= 10'h000;
      done <= 1'b0;
    end else begin
      cmpSync0_q <= cmpIn;
      cmpSync1_q <= cmpSync0_q;
      done <= 1'b0;
      // Count clocks since the trial code changed, so that the synchronised comparator has caught up
      if (settle_q != 2'h3) begin
        settle_q <= settle_q + 2'h1;
      end
      if (start) begin
        busy_q <= 1'b1;
        bit_q <= 4'h9;
        settle_q <= 2'h0;
        dacCode <= 10'h200;
      end else if (tick && busy_q && settle_q[1]) begin
        if (bit_q == 4'h0) begin
          result <= trial;
          dacCode <= trial;
          done <= 1'b1;
          busy_q <= 1'b0;
        end else begin
          dacCode <= trial | (10'h001 << (bit_q - 4'h1));
          bit_q <= bit_q - 4'h1;
          settle_q <= 2'h0;
        end
      end
    end
  end

endmodule // sacc_sar_core
`default_nettype wire

// File: sacc_conv_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_conv_ctrl_sva (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata,
  // Analog side
  input wire [15:0] pinSel,
  input wire tempSel,
  input wire ldoSel,
  input wire vddSel,
  input wire gndSel,
  input wire convPowerOn,
  input wire convDoneIrq
);
  // Shadow copies of the written registers
  reg [4:0] chan_q;
  reg [4:0] div_q;
  reg ien_q;
  reg burst_q;
  reg warm_q;
  wire [19:0] selAll = {gndSel, vddSel, ldoSel, tempSel, pinSel};
  wire muxWr = regWr && regAddr == 3'h2;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_q <= 5'h1F;
      div_q <= 5'h1F;
      ien_q <= 1'b0;
      burst_q <= 1'b0;
      warm_q <= 1'b0;
    end else begin
      warm_q <= 1'b1;
      if (muxWr) chan_q <= regWdata[4:0];
      if (regWr && regAddr == 3'h1) div_q <= regWdata[7:3];
      if (regWr && regAddr == 3'h6) ien_q <= regWdata[0];
      if (regWr && regAddr == 3'h0) burst_q <= regWdata[4];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SEL_ONEHOT: assert property ($onehot0(selAll))
    else $error("several sources selected");
  AST_SEL_PIN: assert property (muxWr && !regWdata[4] |-> ##2
    pinSel == 16'h0001 << $past(regWdata[3:0], 2))
    else $error("wrong pin selected");
  AST_SEL_INT: assert property (muxWr && regWdata[4:2] == 3'h4 |->
    ##2 {gndSel, vddSel, ldoSel, tempSel} == 4'h1 << $past(regWdata[1:0], 2))
    else $error("wrong internal source");
  AST_SEL_NONE: assert property (muxWr && regWdata[4:0] >= 5'h14 |-> ##2 selAll == 20'h00000)
    else $error("source selected for open code");
  AST_MUX_RDBK: assert property ($past(regRd && regAddr == 3'h2) |->
    regRdata == {3'h0, $past(chan_q)})
    else $error("channel readback wrong");
  AST_CFG_RDBK: assert property ($past(regRd && regAddr == 3'h1) |->
    regRdata == {$past(div_q), 3'h0})
    else $error("divide readback wrong");
  AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside read cycle");
  AST_IRQ_EN: assert property (convDoneIrq |-> $past(ien_q))
    else $error("irq while disabled");
  AST_POWER_ON: assert property (warm_q && !burst_q && !$past(burst_q) |-> convPowerOn)
    else $error("powered down outside burst");
  cover property (regWr && regAddr == 3'h0 && regWdata[6]);
  cover property ($rose(convDoneIrq));
  cover property (burst_q && convPowerOn);
endmodule // sacc_conv_ctrl_sva

bind sacc_conv_ctrl sacc_conv_ctrl_sva i_sacc_conv_ctrl_sva (.clk(clk), .nrst(nrst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .pinSel(pinSel), .tempSel(tempSel), .ldoSel(ldoSel), .vddSel(vddSel), .gndSel(gndSel),
  .convPowerOn(convPowerOn), .convDoneIrq(convDoneIrq));
`default_nettype wire

// File: sacc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_analog_model (
  // Clock
  input wire clk,
  // Source select and trial code
  input wire [15:0] pinSel,
  input wire tempSel,
  input wire ldoSel,
  input wire vddSel,
  input wire gndSel,
  input wire [9:0] dacCode,
  // Comparator
  output logic cmpIn
);
  logic toggle_q = 1'b0;
  logic [9:0] lvl;
  int k;
  always @(posedge clk) toggle_q <= !toggle_q;
  always @* begin
    lvl = 10'h000;
    for (k = 0; k < 16; k++) begin
      // Selected pins act as analog inputs with their digital drivers off
      if (pinSel[k]) lvl = 10'h155 + 10'h017 * k[9:0];
    end
    if (tempSel) lvl = 10'h1C3;
    if (ldoSel) lvl = 10'h2E8;
    if (vddSel) lvl = 10'h3FF;
    // Open input wanders every cycle
    cmpIn = |{pinSel, tempSel, ldoSel, vddSel, gndSel} ? lvl >= dacCode : toggle_q;
  end
endmodule // sacc_analog_model
`default_nettype wire

// File: sacc_conv_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_conv_ctrl_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic extStartPin = 1'b1;
  logic [2:0] timerOvf = 3'h0;
  logic [1:0] hfCnt = 2'h0;
  wire [7:0] regRdata;
  wire [9:0] dacCode;
  wire [15:0] pinSel;
  wire tempSel, ldoSel, vddSel, gndSel, trackEn, convPowerOn, convDoneIrq, cmpIn;
  int failures = 0;
  int checksDone = 0;
  logic [7:0] d;
  logic [7:0] h;
  int n;
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) hfCnt <= hfCnt + 2'h1;
  sacc_conv_ctrl i_sacc_conv_ctrl (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .extStartPin(extStartPin), .timerOvf(timerOvf), .hfOsc(hfCnt[1]), .cmpIn(cmpIn),
    .dacCode(dacCode), .pinSel(pinSel), .tempSel(tempSel), .ldoSel(ldoSel), .vddSel(vddSel),
    .gndSel(gndSel), .trackEn(trackEn), .convPowerOn(convPowerOn), .convDoneIrq(convDoneIrq));
  sacc_analog_model i_sacc_analog_model (.clk(clk), .pinSel(pinSel), .tempSel(tempSel),
    .ldoSel(ldoSel), .vddSel(vddSel), .gndSel(gndSel), .dacCode(dacCode), .cmpIn(cmpIn));
  function automatic logic [9:0] lvl(input int c);
    if (c < 16) return 10'h155 + 10'h017 * c[9:0];
    return c == 16 ? 10'h1C3 : 10'h2E8;
  endfunction
  task automatic completeRun;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask
  task automatic waitDone;
    d = 8'h00;
    for (n = 0; n < 2000 && d[7] !== 1'b1; n++) rd(3'h0, d);
    if (d[7] !== 1'b1) begin
      failures++;
      $display("[ERR] %0t done never set", $time);
      completeRun();
    end
  endtask
  task automatic res(input logic [15:0] exp);
    rd(3'h3, h);
    rd(3'h4, d);
    chk({h, d}, exp);
  endtask
  task automatic testReset;
    rd(3'h0, d);
    chk(d, 8'h00);
    rd(3'h1, d);
    chk(d, 8'hF8);
    rd(3'h2, d);
    chk(d, 8'h1F);
    rd(3'h7, d);
    chk(d, 8'h00);
    chk(trackEn, 1'b1);
    $display("reset test done");
  endtask
  task automatic testMux;
    for (int c = 0; c < 32; c++) begin
      wr(3'h2, 8'(c));
      repeat (2) @(posedge clk);
      #1 chk({gndSel, vddSel, ldoSel, tempSel, pinSel}, c < 20 ? 20'h1 << c : 20'h0);
    end
    $display("mux test done");
  endtask
  task automatic testSoft;
    wr(3'h2, 8'h03);
    wr(3'h1, 8'h10);
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h40);
    rd(3'h0, d);
    chk(d[6], 1'b1);
    chk(trackEn, 1'b0);
    waitDone();
    rd(3'h0, d);
    chk(d[6], 1'b0);
    chk(convDoneIrq, 1'b1);
    res(lvl(3));
    wr(3'h0, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(convDoneIrq, 1'b0);
    $display("software test done");
  endtask
  task automatic testTrack;
    wr(3'h0, 8'h20);
    wr(3'h0, 8'h60);
    repeat (6) @(posedge clk);
    #1 chk(trackEn, 1'b1);
    repeat (14) @(posedge clk);
    #1 chk(trackEn, 1'b0);
    waitDone();
    res(lvl(3));
    wr(3'h0, 8'h00);
    $display("track test done");
  endtask
  task automatic testTimer;
    for (int t = 1; t < 4; t++) begin
      wr(3'h0, 8'(t));
      @(posedge clk) timerOvf <= 3'h1 << (t % 3);
      @(posedge clk) timerOvf <= 3'h0;
      rd(3'h0, d);
      chk(d[6], 1'b0);
      @(posedge clk) timerOvf <= 3'h1 << (t - 1);
      @(posedge clk) timerOvf <= 3'h0;
      waitDone();
      res(lvl(3));
      wr(3'h0, 8'(t));
    end
    $display("timer test done");
  endtask
  task automatic testExt;
    wr(3'h2, 8'h10);
    wr(3'h0, 8'h24);
    @(posedge clk) extStartPin <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(trackEn, 1'b1);
    rd(3'h0, d);
    chk(d[6], 1'b0);
    @(posedge clk) extStartPin <= 1'b1;
    waitDone();
    res(lvl(16));
    wr(3'h0, 8'h04);
    $display("external test done");
  endtask
  task automatic testBurst;
    wr(3'h2, 8'h05);
    wr(3'h5, 8'h01);
    wr(3'h0, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk(convPowerOn, 1'b0);
    wr(3'h0, 8'h50);
    wr(3'h0, 8'h50);
    chk(convPowerOn, 1'b1);
    waitDone();
    res(4 * lvl(5));
    repeat (4) @(posedge clk);
    #1 chk(convPowerOn, 1'b0);
    rd(3'h0, d);
    chk(d[6], 1'b0);
    $display("burst test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    testReset();
    testMux();
    testSoft();
    testTrack();
    testTimer();
    testExt();
    testBurst();
    completeRun();
  end
endmodule // sacc_conv_ctrl_test
`default_nettype wire
